// *** logic/mstx_baud.sv ***
// base clock prescaler and 5-bit divisor producing half-bit ticks
`timescale 1ns/1ps
`include "mstx_map.svh"
module mstx_baud (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [2:0] clk_sel,
	input wire logic [4:0] divisor,
	output logic half_tick
);
	import mstx_pkg::*;

	// -----------------------------------------------------------------
	// selection arithmetic
	// -----------------------------------------------------------------
	// low-bit mask of the prescaler for a power-of-two division
	function automatic logic [4:0] sel_mask(input logic [2:0] sel);
		logic [5:0] full;
		full = 6'h00;
		if (sel > `MSTX_SEL_MAX)
			full = 6'h1f;
		else
			full = (6'h01 << sel) - 6'h01;
		return full[4:0];
	endfunction

	logic [4:0] pre_cnt; // free prescaler while running
	logic [4:0] k_cnt; // divisor counter in base clocks
	wire logic [4:0] mask = sel_mask(clk_sel);
	wire logic base_en = (pre_cnt & mask) == mask;
	// divisor values below four act as four
	wire logic [4:0] k_eff = (divisor < `MSTX_DIV_MIN) ? `MSTX_DIV_MIN : divisor;
	wire logic k_last = k_cnt == (k_eff - 5'h01);

	// -----------------------------------------------------------------
	// counters, held cleared while stopped to save power
	// -----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_cnt <= 5'h00;
			k_cnt <= 5'h00;
			half_tick <= 1'b0;
		end
		else if (!run)
		begin
			pre_cnt <= 5'h00;
			k_cnt <= 5'h00;
			half_tick <= 1'b0;
		end
		else
		begin
			pre_cnt <= pre_cnt + 5'h01;
			half_tick <= base_en && k_last;
			if (base_en)
				k_cnt <= k_last ? 5'h00 : k_cnt + 5'h01;
		end
	end
endmodule

// *** logic/mstx_map.svh ***
// register map, field positions, reset values and divider constants
`ifndef MSTX_MAP_SVH
`define MSTX_MAP_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define MSTX_IDX_STATUS 16'hff47
`define MSTX_IDX_BUFFER 16'hff4a
`define MSTX_IDX_LENGTH 16'hff4b
`define MSTX_IDX_CTL0 16'hff4c
`define MSTX_IDX_CLKSEL 16'hff4d
`define MSTX_IDX_BAUD 16'hff4e

// -----------------------------------------------------------------
// reset values and writable masks
// -----------------------------------------------------------------
`define MSTX_RST_BUFFER 8'hff
`define MSTX_RST_LENGTH 8'h07
`define MSTX_RST_CTL0 8'h10
`define MSTX_RST_CLKSEL 8'h00
`define MSTX_RST_BAUD 8'h1f
`define MSTX_MASK_LENGTH 8'h07
`define MSTX_MASK_CTL0 8'h93
`define MSTX_MASK_CLKSEL 8'h07
`define MSTX_MASK_BAUD 8'h1f

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define MSTX_BIT_ENABLE 7
`define MSTX_BIT_ORDER 4
`define MSTX_BIT_FORMAT 1
`define MSTX_BIT_IDLE 0
`define MSTX_BIT_BUSY 7

// -----------------------------------------------------------------
// divider limits
// -----------------------------------------------------------------
`define MSTX_DIV_MIN 5'h04
`define MSTX_SEL_MAX 3'h5

`endif

// *** logic/mstx_pkg.sv ***
// shared types of the serial transmitter
package mstx_pkg;
	// transmit engine states
	typedef enum logic {MSTX_IDLE, MSTX_SENDING} mstx_state_t;
endpackage

// *** logic/mstx_top.sv ***
// manchester / bit-sequential serial transmitter with apb registers
//
// Functional notes
// R1: stopped, manchester and sequential modes share pin
// R2: stopped mode idles logic, no output activity
// R3: manchester mode with length, idle level, order
// R4: sequential nrz mode with same options
// R5: buffer write starts only when enabled
// R6: byte loads shift register, shifted to pin
// R7: control bit 1 selects output code
// R8: transmit buffer resets to ff, byte written
// R9: software sets length before data byte
// R10: start interrupt paces continuous transfers
// R11: length code plus one gives bit count
// R12: length resets to seven, upper bits zero
// R13: short transfers use low-order buffer bits
// R14: control resets to 10, byte writable
// R15: enable, order, format, idle level positions
// R16: busy flag high through whole transmission
// R17: bit rate is base clock over k over 2
// R18: software disables before changing settings
// R19: manchester one is low-then-high, zero high-then-low
// R20: pin holds idle level between transfers
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "mstx_map.svh"
module mstx_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic serial_out_pin,
	output logic transmit_start_irq
);
	import mstx_pkg::*;

	// -----------------------------------------------------------------
	// helper functions
	// -----------------------------------------------------------------
	// word address match for a register index
	function automatic logic reg_hit(input logic [17:0] addr, input logic [15:0] idx);
		return addr == {idx, 2'b00};
	endfunction

	// bit now on the wire: lsb-first reads bit 0, msb-first bit 7
	function automatic logic out_bit(input logic [7:0] sh, input logic lsb);
		return lsb ? sh[0] : sh[7];
	endfunction

	// level of the first half of a bit period
	function automatic logic first_half(input logic b, input logic seq);
		return seq ? b : ~b;
	endfunction

	// -----------------------------------------------------------------
	// registers and state
	// -----------------------------------------------------------------
	logic [7:0] transmit_buffer; // last written data byte
	logic [7:0] transmit_length; // bit count code
	logic [7:0] generator_control; // enable, order, format, idle level
	logic [7:0] base_clock_select_reg; // base clock select
	logic [7:0] baud_divisor_reg; // divisor k
	mstx_state_t state; // engine state
	logic [7:0] shift_reg; // outgoing bits
	logic [3:0] bits_left; // bits still to send, current included
	logic phase; // 0 first half, 1 second half
	logic pending; // next byte waiting in the buffer
	logic half_tick; // half-bit strobe

	// -----------------------------------------------------------------
	// field decode
	// -----------------------------------------------------------------
	// R15: control field positions
	wire logic operation_enable = generator_control[`MSTX_BIT_ENABLE];
	wire logic bit_order_select = generator_control[`MSTX_BIT_ORDER];
	// R7: format bit picks the output code
	wire logic format_select = generator_control[`MSTX_BIT_FORMAT];
	wire logic idle_level = generator_control[`MSTX_BIT_IDLE];
	wire logic [2:0] base_clock_field = base_clock_select_reg[2:0];
	wire logic [4:0] baud_divisor_field = baud_divisor_reg[4:0];
	wire logic [2:0] length_code = transmit_length[2:0];
	wire logic transmit_busy_flag = state == MSTX_SENDING;
	wire logic [7:0] generator_state = {transmit_busy_flag, 7'h00};

	// -----------------------------------------------------------------
	// apb decode
	// -----------------------------------------------------------------
	wire logic hit_buf = reg_hit(paddr, `MSTX_IDX_BUFFER);
	wire logic hit_len = reg_hit(paddr, `MSTX_IDX_LENGTH);
	wire logic hit_ctl = reg_hit(paddr, `MSTX_IDX_CTL0);
	wire logic hit_sel = reg_hit(paddr, `MSTX_IDX_CLKSEL);
	wire logic hit_baud = reg_hit(paddr, `MSTX_IDX_BAUD);
	wire logic hit_stat = reg_hit(paddr, `MSTX_IDX_STATUS);
	wire logic hit_any = hit_buf | hit_len | hit_ctl | hit_sel | hit_baud | hit_stat;
	wire logic wr_en = psel & penable & pwrite & pstrb[0];
	wire logic setup = psel & ~penable;
	wire logic tx_wr = wr_en & hit_buf;
	// byte that a load takes: a same-cycle write wins over the stored one
	wire logic [7:0] next_buffer = tx_wr ? pwdata[7:0] : transmit_buffer;
	wire logic [7:0] rd_mux = hit_buf ? transmit_buffer :
		hit_len ? transmit_length :
		hit_ctl ? generator_control :
		hit_sel ? base_clock_select_reg :
		hit_baud ? baud_divisor_reg :
		hit_stat ? generator_state : 8'h00;

	// zero wait state slave, error on unmapped access
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit_any;

	// -----------------------------------------------------------------
	// engine datapath
	// -----------------------------------------------------------------
	// R13: msb-first aligns the low bits to bit 7, lsb-first keeps them
	wire logic [7:0] load_val = bit_order_select ? next_buffer :
		next_buffer << (3'h7 - length_code);
	wire logic [7:0] shifted = bit_order_select ? shift_reg >> 1 : shift_reg << 1;
	wire logic cur_bit = out_bit(shift_reg, bit_order_select);
	// R19: first half is the inverse of the bit in manchester mode
	wire logic load_first = first_half(out_bit(load_val, bit_order_select), format_select);
	wire logic next_first = first_half(out_bit(shifted, bit_order_select), format_select);
	// R5: start only from idle with operation enabled
	wire logic start_now = tx_wr & operation_enable & ~transmit_busy_flag;
	wire logic last_tick = half_tick & phase & (bits_left == 4'h1);
	wire logic chain = pending | tx_wr;

	// -----------------------------------------------------------------
	// register writes
	// -----------------------------------------------------------------
	// R8: buffer and R14: control reset values, byte writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			transmit_buffer <= `MSTX_RST_BUFFER;
			transmit_length <= `MSTX_RST_LENGTH;
			generator_control <= `MSTX_RST_CTL0;
			base_clock_select_reg <= `MSTX_RST_CLKSEL;
			baud_divisor_reg <= `MSTX_RST_BAUD;
		end
		else if (wr_en)
		begin
			if (hit_buf)
				transmit_buffer <= pwdata[7:0];
			// R12: upper length bits stay zero
			if (hit_len)
				transmit_length <= pwdata[7:0] & `MSTX_MASK_LENGTH;
			if (hit_ctl)
				generator_control <= pwdata[7:0] & `MSTX_MASK_CTL0;
			if (hit_sel)
				base_clock_select_reg <= pwdata[7:0] & `MSTX_MASK_CLKSEL;
			if (hit_baud)
				baud_divisor_reg <= pwdata[7:0] & `MSTX_MASK_BAUD;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup)
			prdata <= {24'h00_0000, rd_mux};
	end

	// -----------------------------------------------------------------
	// baud generator
	// -----------------------------------------------------------------
	// R17: k base clocks per half bit, two halves per bit
	mstx_baud u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.run(transmit_busy_flag),
		.clk_sel(base_clock_field),
		.divisor(baud_divisor_field),
		.half_tick(half_tick)
	);

	// -----------------------------------------------------------------
	// transmit engine
	// -----------------------------------------------------------------
	// R1: every mode drives the one serial pin
	// stopping wins over any transfer in flight, pending byte is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= MSTX_IDLE;
			shift_reg <= 8'h00;
			bits_left <= 4'h0;
			phase <= 1'b0;
			pending <= 1'b0;
			serial_out_pin <= 1'b0;
			transmit_start_irq <= 1'b0;
		end
		else if (!operation_enable)
		begin
			// R2: stopped mode clears busy and holds the pin
			state <= MSTX_IDLE;
			pending <= 1'b0;
			phase <= 1'b0;
			serial_out_pin <= idle_level;
			transmit_start_irq <= 1'b0;
		end
		else
		begin
			transmit_start_irq <= 1'b0;
			unique case (state)
				MSTX_IDLE:
				begin
					// R20: idle level between transfers
					serial_out_pin <= idle_level;
					if (start_now)
					begin
						// R6: R11: load shift register and count
						state <= MSTX_SENDING;
						shift_reg <= load_val;
						bits_left <= {1'b0, length_code} + 4'h1;
						phase <= 1'b0;
						serial_out_pin <= load_first;
						// R10: start interrupt frees the buffer
						transmit_start_irq <= 1'b1;
					end
				end
				MSTX_SENDING:
				begin
					if (tx_wr)
						pending <= 1'b1;
					if (half_tick && !phase)
					begin
						// R3: R4: second half carries the bit itself
						phase <= 1'b1;
						serial_out_pin <= cur_bit;
					end
					else if (half_tick && bits_left != 4'h1)
					begin
						shift_reg <= shifted;
						bits_left <= bits_left - 4'h1;
						phase <= 1'b0;
						serial_out_pin <= next_first;
					end
					else if (last_tick && chain)
					begin
						// R16: continuous transfer keeps busy high
						shift_reg <= load_val;
						bits_left <= {1'b0, length_code} + 4'h1;
						phase <= 1'b0;
						pending <= 1'b0;
						serial_out_pin <= load_first;
						transmit_start_irq <= 1'b1;
					end
					else if (last_tick)
					begin
						state <= MSTX_IDLE;
						serial_out_pin <= idle_level;
					end
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// stopping, starting, pin level and bit order checks
	a_stop_clears_busy: assert property (!operation_enable |=> !transmit_busy_flag) // R2
		else $error("busy while stopped");
	// R5: start pulse and busy follow an enabled buffer write
	a_start_on_write: assert property (start_now |=> transmit_busy_flag && transmit_start_irq) // R5
		else $error("enabled write did not start");
	a_no_start_stopped: assert property (tx_wr && !operation_enable |=> !transmit_start_irq) // R5
		else $error("start while disabled");
	a_count_loaded: assert property (start_now |=> bits_left == $past(length_code) + 4'h1) // R11
		else $error("bit count not code plus one");
	a_length_upper: assert property (transmit_length[7:3] == 5'h00) // R12
		else $error("length upper bits set");
	a_idle_pin: assert property (!transmit_busy_flag && !start_now // R20
		|=> serial_out_pin == $past(idle_level))
		else $error("pin not at idle level");
	a_manch_mid: assert property (transmit_busy_flag && half_tick && !phase && !format_select // R19
		&& operation_enable |=> serial_out_pin != $past(serial_out_pin))
		else $error("no manchester mid transition");
	a_seq_mid: assert property (transmit_busy_flag && half_tick && !phase && format_select // R4
		&& operation_enable |=> $stable(serial_out_pin))
		else $error("sequential level changed mid bit");
	a_busy_chain: assert property (last_tick && chain && operation_enable // R16
		|=> transmit_busy_flag [*2])
		else $error("busy dropped in continuous transfer");
	a_msb_align: assert property (start_now && !bit_order_select |=> // R13
		shift_reg[7] == $past(next_buffer[length_code]))
		else $error("msb-first did not start at top low bit");

	// covers of the main transfer kinds
	c_manch_xfer: cover property (start_now && !format_select);
	c_seq_xfer: cover property (start_now && format_select);
	c_chain: cover property (transmit_start_irq && transmit_busy_flag ##1 last_tick && chain);
	c_lsb_short: cover property (start_now && bit_order_select && length_code != 3'h7);
endmodule

// *** verification/mstx_rx.sv ***
// receiver model that samples the serial line once in the middle of each half bit
`timescale 1ns/1ps
module mstx_rx (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic line,
	input wire logic start,
	input wire logic [7:0] half_len,
	output logic [15:0] halves,
	output logic done
);
	logic [7:0] cnt; // edge count, set to three on each edge that sees the start pulse high
	logic [7:0] nxt; // edge count of the next sample
	logic [4:0] taken; // halves captured so far
	// a frame is complete after sixteen halves
	assign done = taken[4];
	// -----------------------------------------------------------------
	// sampling
	// -----------------------------------------------------------------
	// restart on every start pulse, then sample mid-half and shift in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 8'h00;
			nxt <= 8'h00;
			taken <= 5'h10;
			halves <= 16'h0000;
		end
		else if (start)
		begin
			cnt <= 8'h03;
			nxt <= {1'b0, half_len[7:1]} + 8'h01;
			taken <= 5'h00;
		end
		else
		begin
			cnt <= cnt + 8'h01;
			if (!taken[4] && cnt == nxt)
			begin
				halves <= {halves[14:0], line};
				taken <= taken + 5'h01;
				nxt <= nxt + half_len;
			end
		end
	end
endmodule

// *** verification/testbench.sv ***
// self-checking testbench of the serial transmitter
`timescale 1ns/1ps
`include "mstx_map.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_out_pin;
	logic transmit_start_irq, rx_done, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] hp; // half-bit length handed to the receiver
	logic [15:0] halves;
	int num_errors = 0;
	int compares = 0;
	int cycles = 0;
	int irqs = 0;
	mstx_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
		.transmit_start_irq(transmit_start_irq));
	mstx_rx rx (.pclk(pclk), .presetn(presetn), .line(serial_out_pin),
		.start(transmit_start_irq), .half_len(hp), .halves(halves), .done(rx_done));
	// -----------------------------------------------------------------
	// clock, hang limit, start pulse count
	// -----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (transmit_start_irq === 1'b1)
			irqs++;
		if (cycles == 20000)
		begin
			num_errors++;
			final_report;
		end
	end
	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task final_report;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer: setup, then access until pready is sampled high
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		// a wait that runs out counts as a mismatch
		check(32'(n < 50), 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rcheck(input logic [15:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		check(rd, exp);
	endtask
	// wait for a start pulse or a finished capture, bounded
	task automatic wait_sig(input logic irq_not_done);
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while ((irq_not_done ? transmit_start_irq : rx_done) !== 1'b1 && n < 400);
		check(32'(n < 400), 32'h1);
	endtask
	// halves on the line, first half in the top bit, idle after the last bit
	function automatic logic [15:0] exp_halves(input logic [7:0] c, input logic [2:0] len,
		input logic [7:0] d);
		logic [15:0] h;
		logic b;
		int n;
		n = len + 1;
		for (int i = 0; i < 8; i++)
		begin
			b = c[`MSTX_BIT_IDLE];
			if (i < n)
				b = c[`MSTX_BIT_ORDER] ? d[i] : d[n - 1 - i];
			h[15 - 2 * i] = (i < n && !c[`MSTX_BIT_FORMAT]) ? ~b : b;
			h[14 - 2 * i] = b;
		end
		return h;
	endfunction
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task t_reset;
		check({31'h0, serial_out_pin}, 32'h0);
		rcheck(`MSTX_IDX_BUFFER, 32'hff);
		rcheck(`MSTX_IDX_LENGTH, 32'h07);
		rcheck(`MSTX_IDX_CTL0, 32'h10);
		rcheck(`MSTX_IDX_STATUS, 32'h00);
		xfer(1'b1, `MSTX_IDX_LENGTH, 8'hff);
		rcheck(`MSTX_IDX_LENGTH, 32'h07);
		xfer(1'b1, `MSTX_IDX_CTL0, 8'hff);
		rcheck(`MSTX_IDX_CTL0, 32'h93);
		xfer(1'b1, `MSTX_IDX_CTL0, 8'h00);
		xfer(1'b1, `MSTX_IDX_STATUS, 8'hff);
		check({31'h0, err}, 32'h0);
		rcheck(`MSTX_IDX_STATUS, 32'h00);
		// unmapped place answers with an error and zero data
		xfer(1'b0, 16'hff50, 8'h00);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
	endtask
	task automatic t_disabled;
		int n;
		n = irqs;
		xfer(1'b1, `MSTX_IDX_BUFFER, 8'h55);
		repeat (40) @(posedge pclk);
		check(32'(irqs - n), 32'h0);
		check({31'h0, serial_out_pin}, 32'h0);
		rcheck(`MSTX_IDX_BUFFER, 32'h55);
		// a write without the low byte strobe leaves the buffer alone
		pstrb <= 4'h0;
		xfer(1'b1, `MSTX_IDX_BUFFER, 8'haa);
		pstrb <= 4'hf;
		rcheck(`MSTX_IDX_BUFFER, 32'h55);
	endtask
	task t_frame(input logic [7:0] c, input logic [2:0] len, input logic [7:0] d,
		input logic [2:0] sel, input logic [4:0] k);
		xfer(1'b1, `MSTX_IDX_CTL0, 8'h00);
		xfer(1'b1, `MSTX_IDX_CLKSEL, {5'h00, sel});
		xfer(1'b1, `MSTX_IDX_BAUD, {3'h0, k});
		xfer(1'b1, `MSTX_IDX_LENGTH, {5'h00, len});
		xfer(1'b1, `MSTX_IDX_CTL0, c);
		hp <= ((k < 5'h04) ? 8'h04 : {3'h0, k}) << sel;
		xfer(1'b1, `MSTX_IDX_BUFFER, d);
		wait_sig(1'b1);
		rcheck(`MSTX_IDX_STATUS, 32'h80);
		wait_sig(1'b0);
		check({16'h0, halves}, {16'h0, exp_halves(c, len, d)});
		// the capture ends about a quarter bit (hp/2 + 1 cycles) before the last half does
		repeat (hp) @(posedge pclk);
		rcheck(`MSTX_IDX_STATUS, 32'h00);
		check({31'h0, serial_out_pin}, {31'h0, c[`MSTX_BIT_IDLE]});
	endtask
	task automatic t_continuous;
		int n;
		t_frame(8'h80, 3'h1, 8'h02, 3'h0, 5'h04);
		n = irqs;
		xfer(1'b1, `MSTX_IDX_BUFFER, 8'h02);
		wait_sig(1'b1);
		xfer(1'b1, `MSTX_IDX_BUFFER, 8'h01);
		rcheck(`MSTX_IDX_STATUS, 32'h80);
		wait_sig(1'b1);
		rcheck(`MSTX_IDX_STATUS, 32'h80);
		wait_sig(1'b0);
		check({16'h0, halves}, {16'h0, exp_halves(8'h80, 3'h1, 8'h01)});
		check(32'(irqs - n), 32'h2);
	endtask
	task automatic t_stop;
		logic moved;
		moved = 1'b0;
		xfer(1'b1, `MSTX_IDX_CTL0, 8'h00);
		xfer(1'b1, `MSTX_IDX_CTL0, 8'h81);
		xfer(1'b1, `MSTX_IDX_BUFFER, 8'h00);
		wait_sig(1'b1);
		xfer(1'b1, `MSTX_IDX_CTL0, 8'h01);
		rcheck(`MSTX_IDX_STATUS, 32'h00);
		repeat (40)
		begin
			@(posedge pclk);
			moved = moved | (serial_out_pin !== 1'b1);
		end
		check({31'h0, moved}, 32'h0);
	endtask
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h00000;
		pwdata = 32'h0;
		pstrb = 4'hf;
		hp = 8'h04;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_disabled;
		t_frame(8'h80, 3'h7, 8'ha5, 3'h0, 5'h04);
		t_frame(8'h91, 3'h2, 8'hd6, 3'h0, 5'h04);
		t_frame(8'h82, 3'h4, 8'h3c, 3'h1, 5'h05);
		t_frame(8'h93, 3'h0, 8'hfe, 3'h0, 5'h04);
		t_frame(8'h80, 3'h5, 8'h9b, 3'h0, 5'h02);
		t_continuous;
		t_stop;
		final_report;
	end
endmodule
